// >>> bench/spsout_ctrl_model.sv
// Controller model: drives the link clock, captures each frame.
// Assumes the sensor data line is driven at all times.
`timescale 1ns/1ps
`default_nettype none
module spsout_ctrl_model (
    output logic link_clk_out,
    input wire logic data_in,
    output logic [17:0] capture_out,
    output logic capture_stb_out
);
    // ****************
    // Idle state
    // ****************
    initial begin
        link_clk_out = 1'b1;
        capture_out = 18'h00000;
        capture_stb_out = 1'b0;
    end

    // ****************
    // Frame read
    // ****************
    // one bit per pulse, caller paces reads
    task automatic read_frame();
        logic [17:0] cap;
        cap = 18'h3FFFF;
        #2.3;
        for (int i = 0; i < 17; i++) begin
            link_clk_out = 1'b0;
            #62.5;
            link_clk_out = 1'b1;
            fork
                automatic int k = i;
                begin
                    #710;
                    cap[17 - k] = data_in;
                end
            join_none
            #62.5;
        end
        // Clock held high past the timeout
        #21500;
        cap[0] = data_in;
        capture_out = cap;
        capture_stb_out = 1'b1;
        #1;
        capture_stb_out = 1'b0;
    endtask : read_frame
endmodule : spsout_ctrl_model
`default_nettype wire

// >>> bench/spsout_top_test.sv
// Self-checking bench of the serial position output.
// Assumes the controller model and a 100 MHz core clock.
`timescale 1ns/1ps
`default_nettype none
`include "spsout_regs.svh"
module spsout_top_test;
    import spsout_pkg::*;
    // ****************
    // Signals
    // ****************
    logic core_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic sync_mode = 1'b1;
    logic link_clk, meas_start, async_active, busy, data, capture_stb;
    spsout_variant_e variant = SPSOUT_FWD;
    logic [15:0] probe_len = 16'h0000;
    spsout_sample_s pos_s = '0;
    spsout_sample_s spd_s = '0;
    logic [17:0] capture;
    logic [17:0] exp_q[$];
    int n_errors = 0;
    int checked = 0;
    int n_starts = 0;
    int cycles = 0;

    always #5 core_clk_in = ~core_clk_in;

    spsout_top i_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk),
        .sync_mode_in(sync_mode), .variant_in(variant), .probe_len_in(probe_len), .pos_sample_in(pos_s),
        .speed_sample_in(spd_s), .meas_start_out(meas_start), .async_active_out(async_active),
        .busy_out(busy), .data_out(data));
    spsout_ctrl_model i_ctrl (.link_clk_out(link_clk), .data_in(data), .capture_out(capture),
        .capture_stb_out(capture_stb));

    // ****************
    // Tasks
    // ****************
    task automatic conclude();
        if (n_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    task automatic compare_bit(input logic e, input logic g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : compare_bit

    task automatic compare_word(input logic [17:0] e, input logic [17:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : compare_word

    task automatic give_sample(input logic [15:0] p, input logic [15:0] s);
        @(negedge core_clk_in);
        pos_s = {1'b1, p};
        spd_s = {1'b1, s};
        @(negedge core_clk_in);
        pos_s.valid = 1'b0;
        spd_s.valid = 1'b0;
    endtask : give_sample

    task automatic read(input logic [15:0] v);
        exp_q.push_back({v, 2'b01});
        @(negedge core_clk_in);
        i_ctrl.read_frame();
    endtask : read

    // ****************
    // Watchers
    // ****************
    always @(posedge capture_stb) begin
        compare_word(exp_q.pop_front(), capture);
    end

    always @(posedge core_clk_in) begin
        cycles++;
        if (meas_start === 1'b1) n_starts++;
        if (cycles == 90000) begin
            n_errors++;
            conclude();
        end
    end

    // ****************
    // Main sequence
    // ****************
    initial begin
        logic [15:0] v, p, s, l, e;
        int n0;
        void'($urandom(32'h06995f1d));
        repeat (3) @(posedge core_clk_in);
        @(negedge core_clk_in);
        rst_n_in = 1'b1;
        repeat (3) @(negedge core_clk_in);
        v = 16'($urandom());
        n0 = n_starts;
        fork
            read(`SPSOUT_RESET_WORD);
            begin
                @(posedge meas_start);
                give_sample(v, ~v);
            end
        join
        compare_bit(1'b1, n_starts == n0 + 1);
        repeat (50000) @(negedge core_clk_in);
        n0 = n_starts;
        read(v);
        compare_bit(1'b1, n_starts == n0 + 1);
        compare_bit(1'b0, async_active);
        n0 = n_starts;
        read(v);
        compare_bit(1'b1, n_starts == n0);
        compare_bit(1'b1, async_active);
        @(negedge core_clk_in);
        sync_mode = 1'b0;
        for (int m = 0; m < 4; m++) begin
            p = 16'($urandom());
            s = 16'($urandom());
            l = (m == 3) ? (p >> 1) : (p | 16'($urandom()));
            e = (m == 0) ? p : (m == 2) ? s : (m == 1) ? l - p : 16'h0000;
            @(negedge core_clk_in);
            variant = spsout_variant_e'((m == 3) ? 1 : m);
            probe_len = l;
            give_sample(p, s);
            read(e);
        end
        compare_bit(1'b0, busy);
        conclude();
    end
endmodule : spsout_top_test
`default_nettype wire

// >>> inc/spsout_pkg.sv
// Types of the serial position output.
// Assumes the constants header is included by users.
package spsout_pkg;
    typedef enum logic [1:0] {
        SPSOUT_FWD,
        SPSOUT_BWD,
        SPSOUT_SPEED
    } spsout_variant_e;
    typedef struct packed {
        logic valid;
        logic [15:0] value;
    } spsout_sample_s;
    typedef struct packed {
        logic clk;
        logic data;
    } spsout_link_s;
endpackage : spsout_pkg

// >>> inc/spsout_regs.svh
// Constants of the serial position output: timing counts and field positions.
// Assumes a 100 MHz core clock.
`ifndef SPSOUT_REGS_SVH
`define SPSOUT_REGS_SVH

`define SPSOUT_CLK_PERIOD_NS 10
`define SPSOUT_DATA_DELAY_NS 605
`define SPSOUT_DATA_DELAY_CYC ((`SPSOUT_DATA_DELAY_NS + `SPSOUT_CLK_PERIOD_NS - 1) / `SPSOUT_CLK_PERIOD_NS)
`define SPSOUT_MAX_RATE_HZ 2000
`define SPSOUT_MEAS_PERIOD_CYC (100000000 / `SPSOUT_MAX_RATE_HZ)
`define SPSOUT_TIMEOUT_NS 20000
`define SPSOUT_TIMEOUT_CYC (`SPSOUT_TIMEOUT_NS / `SPSOUT_CLK_PERIOD_NS)
`define SPSOUT_WORD_BITS 16
`define SPSOUT_WORD_MSB 15
`define SPSOUT_RESET_WORD 16'h0000

`endif

// >>> rtl/spsout_delay.sv
// Fixed delay line for the serial data bit.
// Assumes a single core clock; the input comes from that clock.
`timescale 1ns/1ps
`default_nettype none
`include "spsout_regs.svh"
module spsout_delay (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic bit_in,
    output logic bit_out
);
    import spsout_pkg::*;
    localparam int DLY = `SPSOUT_DATA_DELAY_CYC;
    logic [DLY-1:0] pipe_q;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pipe_q <= '1;
        end else begin
            pipe_q <= {pipe_q[DLY-2:0], bit_in};
        end
    end

    assign bit_out = pipe_q[DLY-1];
endmodule : spsout_delay
`default_nettype wire

// >>> rtl/spsout_top.sv
// Serial synchronous position output of an absolute linear sensor.
// Assumes the link clock comes from the controller and the sample source
// from core-clock logic.
// What this block does
// - Data bit changes 630 to 640 ns after rise
// - Word shifts out MSB first
// - One bit per controller clock pulse
// - Sync mode: first edge starts measurement
// - Triggered result appears in next read
// - Sync data at most one cycle old
// - Reads too fast: fall to async mode
// - Async mode: fixed internal measuring cycle
// - Async rate at most 2000 per second
// - Code proportional to element position
// - Forward variant counts away from head
// - Backward variant counts toward head
// - Speed variant sends speed value
// - Values absolute, no homing needed
`timescale 1ns/1ps
`default_nettype none
`include "spsout_regs.svh"
module spsout_top (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic link_clk_in,
    input wire logic sync_mode_in,
    input wire spsout_pkg::spsout_variant_e variant_in,
    input wire logic [15:0] probe_len_in,
    input wire spsout_pkg::spsout_sample_s pos_sample_in,
    input wire spsout_pkg::spsout_sample_s speed_sample_in,
    output logic meas_start_out,
    output logic async_active_out,
    output logic busy_out,
    output logic data_out
);
    import spsout_pkg::*;

    // ************************************************
    // Link clock sampling
    // ************************************************
    logic clk_s1_q;
    logic clk_s2_q;
    logic clk_s3_q;
    logic rise;
    logic fall;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            clk_s1_q <= 1'b1;
            clk_s2_q <= 1'b1;
            clk_s3_q <= 1'b1;
        end else begin
            clk_s1_q <= link_clk_in;
            clk_s2_q <= clk_s1_q;
            clk_s3_q <= clk_s2_q;
        end
    end

    assign rise = clk_s2_q & ~clk_s3_q;
    assign fall = ~clk_s2_q & clk_s3_q;

    // ************************************************
    // Measured word
    // ************************************************
    function automatic logic [15:0] code_of(input spsout_variant_e v, input logic [15:0] pos,
                                            input logic [15:0] spd, input logic [15:0] len);
        case (v)
            SPSOUT_FWD: code_of = pos;
            SPSOUT_BWD: code_of = (len >= pos) ? 16'(len - pos) : 16'h0000;
            SPSOUT_SPEED: code_of = spd;
            default: code_of = pos;
        endcase
    endfunction : code_of

    logic [15:0] latest_q;
    logic fresh_q;

    // Code from sample, no reference run
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            latest_q <= `SPSOUT_RESET_WORD;
        end else if (pos_sample_in.valid) begin
            latest_q <= code_of(variant_in, pos_sample_in.value, speed_sample_in.value, probe_len_in);
        end
    end

    // ************************************************
    // Update mode and measurement trigger
    // ************************************************
    localparam int MEAS_CYC = `SPSOUT_MEAS_PERIOD_CYC;
    logic [19:0] meas_cnt_q;
    logic meas_pend_q;
    logic async_q;
    logic first_edge;
    logic in_frame_q;

    assign first_edge = fall & ~in_frame_q;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meas_cnt_q <= 20'h00000;
        end else if (meas_start_out) begin
            meas_cnt_q <= 20'(MEAS_CYC - 1);
        end else if (meas_cnt_q != 20'h00000) begin
            meas_cnt_q <= meas_cnt_q - 20'h00001;
        end
    end

    // Start on read or internal tick
    always_comb begin
        if (meas_cnt_q != 20'h00000) begin
            meas_start_out = 1'b0;
        end else if (sync_mode_in && !async_q) begin
            meas_start_out = first_edge;
        end else begin
            meas_start_out = 1'b1;
        end
    end

    // Fall back when polled too fast
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            async_q <= 1'b0;
        end else if (!sync_mode_in) begin
            async_q <= 1'b0;
        end else if (first_edge && meas_cnt_q != 20'h00000) begin
            async_q <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meas_pend_q <= 1'b0;
        end else if (meas_start_out) begin
            meas_pend_q <= 1'b1;
        end else if (pos_sample_in.valid) begin
            meas_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fresh_q <= 1'b0;
        end else begin
            fresh_q <= pos_sample_in.valid;
        end
    end

    assign async_active_out = async_q | ~sync_mode_in;

    // ************************************************
    // Shifter
    // ************************************************
    localparam int TMO_CYC = `SPSOUT_TIMEOUT_CYC;
    logic [15:0] shift_q;
    logic [4:0] bits_q;
    logic [11:0] idle_cnt_q;
    logic line_q;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            in_frame_q <= 1'b0;
            shift_q <= `SPSOUT_RESET_WORD;
            bits_q <= 5'd0;
            line_q <= 1'b1;
        end else if (first_edge) begin
            in_frame_q <= 1'b1;
            shift_q <= latest_q;
            bits_q <= 5'd0;
        end else if (in_frame_q && rise) begin
            // One bit per rise, MSB first
            if (bits_q < 5'd16) begin
                line_q <= shift_q[`SPSOUT_WORD_MSB];
                shift_q <= {shift_q[14:0], 1'b0};
                bits_q <= bits_q + 5'd1;
            end else begin
                line_q <= 1'b0;
            end
        end else if (in_frame_q && idle_cnt_q == 12'(TMO_CYC)) begin
            in_frame_q <= 1'b0;
            line_q <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            idle_cnt_q <= 12'h000;
        end else if (!in_frame_q || !clk_s2_q || rise) begin
            idle_cnt_q <= 12'h000;
        end else if (idle_cnt_q != 12'(TMO_CYC)) begin
            idle_cnt_q <= idle_cnt_q + 12'h001;
        end
    end

    assign busy_out = in_frame_q;

    spsout_delay u_delay (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .bit_in(line_q),
        .bit_out(data_out)
    );

    // ************************************************
    // Assertions
    // ************************************************
    AST_SIXTEEN_BITS: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        bits_q <= 5'd16) else $error("more than sixteen bits shifted");
    AST_MSB_FIRST: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (in_frame_q && rise && !first_edge && bits_q == 5'd0) |=> line_q == $past(shift_q[15]))
        else $error("first bit not msb");
    AST_ONE_BIT: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (in_frame_q && !rise && !first_edge) |=> bits_q == $past(bits_q)) else $error("bit without pulse");
    AST_RATE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        meas_start_out |=> !meas_start_out [*8]) else $error("measurement too soon");
    AST_SYNC_START: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (sync_mode_in && !async_q && first_edge && meas_cnt_q == 20'h00000) |-> meas_start_out)
        else $error("read did not start measurement");
    AST_FALLBACK: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (sync_mode_in && first_edge && meas_cnt_q != 20'h00000) |=> async_active_out)
        else $error("no fallback to async");
    AST_FROZEN: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (first_edge) |=> shift_q == $past(latest_q)) else $error("word not frozen at frame start");
    AST_DELAY: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        $changed(line_q) |-> ##61 data_out == $past(line_q, 61)) else $error("output delay wrong");
    AST_TIMEOUT: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (in_frame_q && idle_cnt_q == 12'(TMO_CYC) && !rise && !first_edge) |=> !in_frame_q && line_q)
        else $error("timeout did not idle line");
    AST_FRESH: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        fresh_q |-> latest_q == $past(code_of(variant_in, pos_sample_in.value,
                                               speed_sample_in.value, probe_len_in)))
        else $error("stored word stale");

    // ************************************************
    // Variant, mode and frame checks
    // ************************************************
    // Forward code is position
    AST_FWD_CODE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (pos_sample_in.valid && variant_in == SPSOUT_FWD) |=> latest_q == $past(pos_sample_in.value))
        else $error("forward code wrong");
    AST_BWD_CODE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (pos_sample_in.valid && variant_in == SPSOUT_BWD && probe_len_in >= pos_sample_in.value)
        |=> latest_q == 16'($past(probe_len_in) - $past(pos_sample_in.value)))
        else $error("backward code wrong");
    AST_BWD_CLAMP: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (pos_sample_in.valid && variant_in == SPSOUT_BWD && probe_len_in < pos_sample_in.value)
        |=> latest_q == 16'h0000) else $error("backward code not clamped");
    AST_SPEED_CODE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (pos_sample_in.valid && variant_in == SPSOUT_SPEED) |=> latest_q == $past(speed_sample_in.value))
        else $error("speed code wrong");
    AST_HOLD: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        !pos_sample_in.valid |=> latest_q == $past(latest_q)) else $error("stored code changed");
    AST_ASYNC_TICK: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (!sync_mode_in && meas_cnt_q == 20'h00000) |-> meas_start_out) else $error("async tick missing");
    AST_PERIOD: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        meas_start_out |=> meas_cnt_q == 20'(MEAS_CYC - 1)) else $error("period not reloaded");
    AST_STICKY: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (sync_mode_in && async_q) |=> async_q) else $error("fallback released early");
    AST_IDLE_HIGH: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        !in_frame_q |=> line_q) else $error("line not idle outside frame");
    AST_ZERO_AFTER: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (in_frame_q && rise && bits_q == 5'h10) |=> !line_q) else $error("no zero after word");
    AST_FRAME_OPEN: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        first_edge |=> in_frame_q && bits_q == 5'h00) else $error("frame did not open");

    // ************************************************
    // Covers
    // ************************************************

    COV_FRAME: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) bits_q == 5'd16);
    COV_FALLBACK: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) $rose(async_q));
    COV_TIMEOUT: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) $fell(in_frame_q));
    COV_BWD: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
        pos_sample_in.valid && variant_in == SPSOUT_BWD);
    COV_SYNC_MEAS: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
        meas_pend_q && pos_sample_in.valid && !async_active_out);
endmodule : spsout_top
`default_nettype wire
